// *** hw/spm_device.sv ***
// Slave end: six data registers, shared status, cross-link attention
//
// Function
// - Three byte registers each direction, six total
// - One status register readable by both sides
// - Master selects register with two address lines
// - Inbound registers: master writes, core reads
// - Outbound registers: core writes, master reads
// - Same address reads opposite direction register
// - Master write strobe latches inbound registers
// - Master may write the status register
// - Master read strobe reads outbound and status
// - Core write of register zero raises attention
// - Master write of zero interrupts core if enabled
// - Producer write sets full, consumer read clears
// - Status shows pending request from each side
// - Only register zero writes raise interrupts
// - Load registers one, two before zero
`timescale 1ns/100ps
`include "spm_defines.svh"
module spm_device
  import spm_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rstn,
  spm_if.dev             port,
  input  wire logic      core_wr,
  input  wire logic      core_rd,
  input  wire spm_sel_t  core_sel,
  input  wire spm_byte_t core_wdata,
  input  wire logic      core_irq_en_wr,
  input  wire logic      core_irq_en_val,
  output spm_byte_t      core_rdata,
  output logic           core_irq,
  output logic           core_irq_en
);
  spm_byte_t  in_reg  [`SPM_NUM_DATA];
  spm_byte_t  out_reg [`SPM_NUM_DATA];
  logic [2:0] in_full_reg;
  logic [2:0] out_full_reg;
  logic       mirq_reg;
  logic       sirq_reg;
  logic [1:0] wr_sync_reg;
  logic [1:0] rd_sync_reg;
  logic       wr_prev_reg;
  logic       rd_prev_reg;
  spm_byte_t  dout_reg;
  logic       doe_reg;
  logic       attn_reg;

  // Edges come from the second synchroniser stage only; select and data
  // stand over the whole held strobe, so they are read live at the edge
  wire m_wr_edge = wr_sync_reg[1] && !wr_prev_reg;
  wire m_rd_edge = rd_sync_reg[1] && !rd_prev_reg;
  wire m_rd_lvl  = rd_sync_reg[1];
  wire m_is_st   = (port.sel == `SPM_SEL_STATUS);
  wire c_is_st   = (core_sel == `SPM_SEL_STATUS);
  wire m_is_r1   = (port.sel == `SPM_SEL_REG1);
  wire m_is_r2   = (port.sel == `SPM_SEL_REG2);
  wire c_is_r1   = (core_sel == `SPM_SEL_REG1);
  wire c_is_r2   = (core_sel == `SPM_SEL_REG2);

  // Status byte assembled field by field at its fixed bit positions
  wire [7:0] status;
  assign status[`SPM_ST_IN_LSB +: `SPM_NUM_DATA]  = in_full_reg;
  assign status[`SPM_ST_OUT_LSB +: `SPM_NUM_DATA] = out_full_reg;
  assign status[`SPM_ST_MIRQ]                     = mirq_reg;
  assign status[`SPM_ST_SIRQ]                     = sirq_reg;

  generate
    for (genvar i = 0; i < `SPM_NUM_DATA; i++)
    begin : g_reg
      wire m_w = m_wr_edge && (port.sel == 2'(i));
      wire m_r = m_rd_edge && (port.sel == 2'(i));
      wire c_w = core_wr && (core_sel == 2'(i));
      wire c_r = core_rd && (core_sel == 2'(i));
      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          in_reg[i]       <= `SPM_BYTE_ZERO;
          out_reg[i]      <= `SPM_BYTE_ZERO;
          in_full_reg[i]  <= 1'b0;
          out_full_reg[i] <= 1'b0;
        end
        else
        begin
          // Each side writes only its own direction, so a write from
          // the reading side of a register never reaches it
          if (m_w)
            in_reg[i] <= port.d_from_master;
          if (c_w)
            out_reg[i] <= core_wdata;
          // Producer set wins over a same-cycle consumer clear
          in_full_reg[i]  <= m_w | (in_full_reg[i] & ~c_r);
          out_full_reg[i] <= c_w | (out_full_reg[i] & ~m_r);
        end
      end
    end
  endgenerate

  // Attention pending until master reads register zero or writes status
  wire c_w0   = core_wr && (core_sel == `SPM_SEL_REG0);
  wire m_w0   = m_wr_edge && (port.sel == `SPM_SEL_REG0);
  wire m_r0   = m_rd_edge && (port.sel == `SPM_SEL_REG0);
  wire m_wst  = m_wr_edge && m_is_st;
  wire c_r0   = core_rd && (core_sel == `SPM_SEL_REG0);
  wire c_wst  = core_wr && c_is_st;
  wire sirq_n = m_w0 | (sirq_reg & ~(c_r0 | c_wst));
  wire mirq_n = c_w0 | (mirq_reg & ~(m_r0 | m_wst));

  // Reads on either side pick the opposite direction at the same select.
  // Explicit selects keep select code 3 off the three-entry arrays.
  wire [7:0] m_data_val = m_is_r1 ? out_reg[1] :
                          m_is_r2 ? out_reg[2] : out_reg[0];
  wire [7:0] c_data_val = c_is_r1 ? in_reg[1] :
                          c_is_r2 ? in_reg[2] : in_reg[0];
  wire [7:0] m_rd_val   = m_is_st ? status : m_data_val;
  wire [7:0] c_rd_val   = c_is_st ? status : c_data_val;

  assign port.d_from_slave        = dout_reg;
  assign port.d_slave_oe          = doe_reg;
  assign port.attention_to_master = attn_reg;

  // Two-stage synchronisers on the master strobes
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_sync_reg <= 2'h0;
      rd_sync_reg <= 2'h0;
    end
    else
    begin
      wr_sync_reg <= {wr_sync_reg[0], !port.wr_n};
      rd_sync_reg <= {rd_sync_reg[0], !port.rd_n};
    end
  end

  // Previous synchronised level, reset to the idle level so that no
  // false strobe edge follows reset
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
    end
    else
    begin
      wr_prev_reg <= wr_sync_reg[1];
      rd_prev_reg <= rd_sync_reg[1];
    end
  end

  // Request flags; a new write of register zero wins over a clear
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mirq_reg <= 1'b0;
      sirq_reg <= 1'b0;
      attn_reg <= 1'b0;
    end
    else
    begin
      mirq_reg <= mirq_n;
      sirq_reg <= sirq_n;
      attn_reg <= mirq_n;
    end
  end

  // Core interrupt follows the pending request only while enabled
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      core_irq_en <= 1'b0;
      core_irq    <= 1'b0;
    end
    else
    begin
      core_irq <= sirq_n && core_irq_en;
      if (core_irq_en_wr)
        core_irq_en <= core_irq_en_val;
    end
  end

  // Read-back registers; status reads touch no flag, and the bus is
  // driven only while the synchronised read strobe is seen
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      core_rdata <= `SPM_BYTE_ZERO;
      dout_reg   <= `SPM_BYTE_ZERO;
      doe_reg    <= 1'b0;
    end
    else
    begin
      core_rdata <= c_rd_val;
      dout_reg   <= m_rd_val;
      doe_reg    <= m_rd_lvl;
    end
  end
endmodule // spm_device

// *** hw/spm_host.sv ***
// Master processor end: runs byte reads and writes over the port pins
`timescale 1ns/100ps
`include "spm_defines.svh"
module spm_host
  import spm_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rstn,
  spm_if.host            port,
  input  wire logic      cmd_valid,
  input  wire logic      cmd_write,
  input  wire spm_sel_t  cmd_sel,
  input  wire spm_byte_t cmd_wdata,
  output logic           cmd_ready,
  output logic           rsp_valid,
  output spm_byte_t      rsp_rdata,
  output logic           attn_seen
);
  localparam logic [2:0] HOLD = `SPM_HOLD_CNT;
  spm_hstate_t state_reg;
  logic [2:0]  cnt_reg;
  logic [1:0]  sel_reg;
  logic [7:0]  wd_reg;
  logic        wr_n_reg;
  logic        rd_n_reg;
  logic        oe_reg;
  logic [1:0]  attn_sync_reg;
  wire         start = (state_reg == SPM_IDLE) && cmd_valid;
  wire         done  = (state_reg != SPM_IDLE) && (cnt_reg == HOLD);

  assign port.sel           = sel_reg;
  assign port.wr_n          = wr_n_reg;
  assign port.rd_n          = rd_n_reg;
  assign port.d_from_master = wd_reg;
  assign port.d_master_oe   = oe_reg;

  // Strobes held several cycles so the slave synchroniser sees them
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= SPM_IDLE;
      cnt_reg   <= 3'h0;
      sel_reg   <= 2'h0;
      wd_reg    <= `SPM_BYTE_ZERO;
      wr_n_reg  <= 1'b1;
      rd_n_reg  <= 1'b1;
      oe_reg    <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= `SPM_BYTE_ZERO;
    end
    else
    begin
      cmd_ready <= (state_reg == SPM_IDLE) && !cmd_valid && !rsp_valid;
      rsp_valid <= 1'b0;
      if (start && cmd_ready)
      begin
        state_reg <= cmd_write ? SPM_WRITE : SPM_READ;
        cnt_reg   <= 3'h0;
        sel_reg   <= cmd_sel;
        wd_reg    <= cmd_wdata;
        oe_reg    <= cmd_write;
        wr_n_reg  <= !cmd_write;
        rd_n_reg  <= cmd_write;
        cmd_ready <= 1'b0;
      end
      else if (done)
      begin
        state_reg <= SPM_IDLE;
        wr_n_reg  <= 1'b1;
        rd_n_reg  <= 1'b1;
        oe_reg    <= 1'b0;
        rsp_valid <= (state_reg == SPM_READ);
        rsp_rdata <= port.d_from_slave;
      end
      else if (state_reg != SPM_IDLE)
        cnt_reg <= cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      attn_sync_reg <= 2'h0;
      attn_seen     <= 1'b0;
    end
    else
    begin
      attn_sync_reg <= {attn_sync_reg[0], port.attention_to_master};
      attn_seen     <= attn_sync_reg[1];
    end
  end
endmodule // spm_host

// *** pkg/spm_defines.svh ***
// Constants for the slave port mailbox
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH
`define SPM_DATA_W     8
`define SPM_ADDR_W     2
`define SPM_NUM_DATA   3
`define SPM_SEL_REG0   2'h0
`define SPM_SEL_REG1   2'h1
`define SPM_SEL_REG2   2'h2
`define SPM_SEL_STATUS 2'h3
`define SPM_ST_IN_LSB  0
`define SPM_ST_OUT_LSB 3
`define SPM_ST_MIRQ    6
`define SPM_ST_SIRQ    7
`define SPM_STATUS_RST 8'h00
`define SPM_HOLD_CNT   3'h4
`define SPM_BYTE_ZERO  8'h00
`endif

// *** pkg/spm_if.sv ***
// Pins between the master processor and the slave port
`timescale 1ns/100ps
interface spm_if;
  logic [1:0] sel;
  logic       wr_n;
  logic       rd_n;
  logic [7:0] d_from_master;
  logic       d_master_oe;
  logic [7:0] d_from_slave;
  logic       d_slave_oe;
  logic       attention_to_master;
  modport dev
  (
    input  sel,
    input  wr_n,
    input  rd_n,
    input  d_from_master,
    input  d_master_oe,
    output d_from_slave,
    output d_slave_oe,
    output attention_to_master
  );
  modport host
  (
    output sel,
    output wr_n,
    output rd_n,
    output d_from_master,
    output d_master_oe,
    input  d_from_slave,
    input  d_slave_oe,
    input  attention_to_master
  );
endinterface

// *** pkg/spm_pkg.sv ***
// Types shared by both ends of the slave port mailbox
package spm_pkg;
  typedef logic [7:0] spm_byte_t;
  typedef logic [1:0] spm_sel_t;
  typedef enum logic [1:0]
  {
    SPM_IDLE  = 2'b00,
    SPM_WRITE = 2'b01,
    SPM_READ  = 2'b10
  } spm_hstate_t;
endpackage

// *** verif/spm_assertions.sv ***
// Pin-level checks on the slave port between host and device
`timescale 1ns/100ps
module spm_assertions
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic [1:0] sel,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic       d_master_oe,
  input wire logic [7:0] d_from_slave,
  input wire logic       d_slave_oe,
  input wire logic       attention_to_master
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // Four low cycles clear the two-stage synchroniser and edge detect
  sequence s_rd;
    (!rd_n)[*4];
  endsequence
  sequence s_rd0;
    (!rd_n && sel == 2'h0)[*4];
  endsequence
  sequence s_rdst;
    (!rd_n && sel == 2'h3)[*4];
  endsequence
  sequence s_wrst;
    (!wr_n && sel == 2'h3)[*4];
  endsequence
  a_oe_on_read: assert property (s_rd |-> d_slave_oe)
    else $error("device not driving during read");
  a_oe_when_idle: assert property (rd_n[*4] |-> !d_slave_oe)
    else $error("device drives without read");
  a_no_bus_fight: assert property (!(d_slave_oe && d_master_oe))
    else $error("both ends drive the bus");
  a_wr_no_drive: assert property ((!wr_n)[*4] |-> !d_slave_oe)
    else $error("device drives during write");
  a_attn_reset: assert property ($rose(rstn) |-> !attention_to_master)
    else $error("attention set out of reset");
  a_rd0_clears: assert property (s_rd0 |-> ##[1:4] !attention_to_master)
    else $error("attention kept after reg0 read");
  a_stw_clears: assert property (s_wrst |-> ##[1:4] !attention_to_master)
    else $error("attention kept after status write");
  // Read data is registered, so it shows the flag one cycle late
  a_status_attn: assert property (s_rdst |->
    d_from_slave[6] == $past(attention_to_master))
    else $error("status bit differs from attention");
endmodule // spm_assertions

// *** verif/tb_slave_port_mailbox.sv ***
// Self-checking bench joining host and device ends of the port
`timescale 1ns/100ps
module tb_slave_port_mailbox
  import spm_pkg::*;
;
  logic      ref_clk = 1'b0;
  logic      rstn = 1'b0;
  logic      cmd_valid = 1'b0;
  logic      cmd_write = 1'b0;
  spm_sel_t  cmd_sel = 2'h0;
  spm_byte_t cmd_wdata = 8'h00;
  logic      core_wr = 1'b0;
  logic      core_rd = 1'b0;
  spm_sel_t  core_sel = 2'h0;
  spm_byte_t core_wdata = 8'h00;
  logic      core_irq_en_wr = 1'b0;
  logic      core_irq_en_val = 1'b0;
  logic      rd_d = 1'b0;
  logic      cmd_ready, rsp_valid, attn_seen, core_irq, core_irq_en;
  spm_byte_t rsp_rdata, core_rdata;
  spm_byte_t hq[$], cq[$], d[3], e[3];
  spm_sel_t  ord[3] = '{2'h1, 2'h2, 2'h0};
  int        err_total = 0, cmp_count = 0, seed = 23, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  spm_if port ();
  spm_host spm_host_i (.ref_clk, .rstn, .port, .cmd_valid, .cmd_write,
    .cmd_sel, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .attn_seen);
  spm_device spm_device_i (.ref_clk, .rstn, .port, .core_wr, .core_rd,
    .core_sel, .core_wdata, .core_irq_en_wr, .core_irq_en_val,
    .core_rdata, .core_irq, .core_irq_en);
  spm_assertions spm_assertions_i (.ref_clk, .rstn, .sel(port.sel),
    .wr_n(port.wr_n), .rd_n(port.rd_n), .d_master_oe(port.d_master_oe),
    .d_from_slave(port.d_from_slave), .d_slave_oe(port.d_slave_oe),
    .attention_to_master(port.attention_to_master));
  task automatic final_report();
    $display("compared %0d, wrong %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk_byte(input spm_byte_t got, input spm_byte_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // A read passes its expected byte in v
  task automatic host_op(input logic wr, spm_sel_t s, spm_byte_t v);
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1)
      @(posedge ref_clk);
    if (!wr)
      hq.push_back(v);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_sel <= s;
    cmd_wdata <= v;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    repeat (9) @(posedge ref_clk);
  endtask
  task automatic core_op(input logic wr, spm_sel_t s, spm_byte_t v);
    @(posedge ref_clk);
    if (!wr)
      cq.push_back(v);
    core_wr <= wr;
    core_rd <= !wr;
    core_sel <= s;
    core_wdata <= v;
    @(posedge ref_clk);
    core_wr <= 1'b0;
    core_rd <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk)
  begin
    if (rsp_valid === 1'b1)
      chk_byte(rsp_rdata, hq.pop_front());
    if (rd_d)
      chk_byte(core_rdata, cq.pop_front());
    rd_d <= core_rd;
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      final_report();
    end
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    core_op(1'b0, 2'h3, 8'h00);
    chk_flag(core_irq_en, 1'b0);
    core_irq_en_wr <= 1'b1;
    core_irq_en_val <= 1'b1;
    @(posedge ref_clk);
    core_irq_en_wr <= 1'b0;
    foreach (ord[i])
    begin
      chk_flag(core_irq, 1'b0);
      d[ord[i]] = spm_byte_t'($random(seed));
      host_op(1'b1, ord[i], d[ord[i]]);
    end
    chk_flag(core_irq, 1'b1);
    core_op(1'b0, 2'h3, 8'h87);
    core_op(1'b0, 2'h3, 8'h87);
    foreach (ord[i])
      core_op(1'b0, ord[i], d[ord[i]]);
    core_op(1'b0, 2'h3, 8'h00);
    chk_flag(core_irq, 1'b0);
    $display("inbound test done");
    foreach (ord[i])
    begin
      e[ord[i]] = spm_byte_t'($random(seed));
      core_op(1'b1, ord[i], e[ord[i]]);
    end
    chk_flag(port.attention_to_master, 1'b1);
    repeat (2) @(posedge ref_clk);
    chk_flag(attn_seen, 1'b1);
    host_op(1'b0, 2'h3, 8'h78);
    foreach (ord[i])
      host_op(1'b0, ord[i], e[ord[i]]);
    host_op(1'b0, 2'h3, 8'h00);
    $display("outbound test done");
    core_op(1'b1, 2'h0, e[1]);
    host_op(1'b1, 2'h3, 8'h5a);
    chk_flag(port.attention_to_master, 1'b0);
    core_op(1'b0, 2'h3, 8'h08);
    host_op(1'b0, 2'h0, e[1]);
    host_op(1'b0, 2'h3, 8'h00);
    $display("status write test done");
    host_op(1'b1, 2'h0, e[2]);
    chk_flag(core_irq, 1'b1);
    core_op(1'b1, 2'h3, 8'h00);
    chk_flag(core_irq, 1'b0);
    core_op(1'b0, 2'h3, 8'h01);
    core_irq_en_wr <= 1'b1;
    core_irq_en_val <= 1'b0;
    @(posedge ref_clk);
    core_irq_en_wr <= 1'b0;
    host_op(1'b1, 2'h0, e[0]);
    chk_flag(core_irq, 1'b0);
    core_op(1'b1, 2'h0, e[0]);
    core_op(1'b0, 2'h3, 8'hc9);
    $display("interrupt enable test done");
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_flag(port.attention_to_master, 1'b0);
    chk_flag(core_irq_en, 1'b0);
    core_op(1'b0, 2'h3, 8'h00);
    chk_flag(core_irq, 1'b0);
    $display("reset test done");
    final_report();
  end
endmodule // tb_slave_port_mailbox
